// ---- hdl/power_loss_cfg.svh ----
/*
  Constants for the power-loss deceleration sequencer: register offsets, field
  positions, reset values and timing counts.
  Assumes a 10 MHz control clock and frequencies held in 0.01 Hz units.
*/
`ifndef POWER_LOSS_CFG_SVH
`define POWER_LOSS_CFG_SVH

`define ADDR_MODE        12'h000
`define ADDR_SUBTRACT    12'h004
`define ADDR_THRESHOLD   12'h008
`define ADDR_SLOPE_ONE   12'h00c
`define ADDR_SLOPE_TWO   12'h010
`define ADDR_SWITCHOVER  12'h014
`define ADDR_REF_FREQ    12'h018
`define ADDR_CONFIG      12'h01c
`define ADDR_COAST_TIME  12'h020
`define ADDR_SET_FREQ    12'h024
`define ADDR_STATUS      12'h028
`define ADDR_OUT_FREQ    12'h02c

`define CFG_INCR_BIT     0
`define CFG_PHASE_BIT    1
`define CFG_NEG_BIT      2

`define RST_MODE         8'h00
`define RST_SUBTRACT     16'h012c
`define RST_THRESHOLD    16'h1770
`define RST_SLOPE_ONE    16'h0032
`define RST_SLOPE_TWO    16'h270f
`define RST_SWITCHOVER   16'h1770
`define RST_REF_FREQ     16'h1770
`define RST_COAST_TIME   16'h270f
`define RST_SET_FREQ     16'h0000
`define RST_ACCEL_STEP   16'h0001
`define SETTING_OFF      16'h270f
`define THRESH_ALWAYS    16'h270f

`define MODE_COAST       8'h00
`define MODE_STOP        8'h01
`define MODE_REACCEL     8'h02
`define MODE_AUTO_STOP   8'h15
`define MODE_AUTO_REACC  8'h16

`define CLK_HZ           10000000
`define TICK_HZ          1000
`define TICK_DIV         ((`CLK_HZ) / (`TICK_HZ))
`define TICKS_PER_10MS   10
`define TICKS_PER_100MS  100

`endif

// ---- hdl/power_loss_decel.sv ----
/*
  Power-loss deceleration sequencer with an APB register file.
  Frequencies are in 0.01 Hz; the ramp advances once per 1 ms tick.
  Assumes supply sensing and start inputs are synchronous to mclk_i and that
  bus_excess_i is the DC bus regulator's request to slow the ramp.
*/
`include "power_loss_cfg.svh"
`default_nettype none
module power_loss_decel
  import power_loss_pkg::*;
(
  input  wire logic                     mclk_i,
  input  wire logic                     rstn_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [11:0]              paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output var  logic [31:0]              prdata_o,
  output var  logic                     pready_o,
  output var  logic                     pslverr_o,
  input  wire power_loss_pkg::supply_t  supply_i,
  input  wire power_loss_pkg::start_t   start_i,
  input  wire logic                     bus_excess_i,
  output var  logic [15:0]              out_freq_o,
  output var  logic                     coast_o,
  output var  logic                     dc_brake_o,
  output var  logic                     power_loss_decel_status_o
);
  import power_loss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [7:0]  power_loss_stop_mode_reg;
  logic [15:0] decel_start_subtract_freq_reg;
  logic [15:0] subtract_start_threshold_reg;
  logic [15:0] power_loss_slope_one_reg;
  logic [15:0] power_loss_slope_two_reg;
  logic [15:0] slope_switchover_freq_reg;
  logic [15:0] ramp_reference_freq_reg;
  logic [2:0]  config_reg;
  logic [15:0] restart_coast_time_reg;
  logic [15:0] set_freq_reg;

  wire time_increment_select    = config_reg[`CFG_INCR_BIT];
  wire phase_loss_detect_enable = config_reg[`CFG_PHASE_BIT];
  wire status_negative          = config_reg[`CFG_NEG_BIT];

  wire setup  = psel_i && !penable_i;
  wire access = psel_i && penable_i;
  wire wr_en  = access && pwrite_i;

  wire known = (paddr_i[1:0] == 2'b00) && (paddr_i <= `ADDR_OUT_FREQ);
  wire read_only = (paddr_i == `ADDR_STATUS) || (paddr_i == `ADDR_OUT_FREQ);

  ////////////////////////////////////////////////////////////////////////////
  // Ramp slopes.
  // Slope times count 0.1 s or 0.01 s units; convert to 1 ms ticks.
  wire [15:0] slope_two_eff = (power_loss_slope_two_reg == `SETTING_OFF) ?
                              power_loss_slope_one_reg : power_loss_slope_two_reg;
  wire [15:0] unit_ticks = time_increment_select ? 16'(`TICKS_PER_10MS) : 16'(`TICKS_PER_100MS);
  wire [31:0] ticks_one_w = power_loss_slope_one_reg * unit_ticks;
  wire [31:0] ticks_two_w = slope_two_eff * unit_ticks;
  wire [15:0] ticks_one = (ticks_one_w[31:16] != 16'h0000) ? 16'hffff : ticks_one_w[15:0];
  wire [15:0] ticks_two = (ticks_two_w[31:16] != 16'h0000) ? 16'hffff : ticks_two_w[15:0];
  logic [15:0] step_one;
  logic [15:0] step_two;
  logic        tick;

  tick_divider u_tick (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .tick_o (tick)
  );

  slope_step u_step_one (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .ref_freq_i   (ramp_reference_freq_reg),
    .time_ticks_i (ticks_one),
    .step_o       (step_one)
  );

  slope_step u_step_two (
    .mclk_i       (mclk_i),
    .rstn_i       (rstn_i),
    .ref_freq_i   (ramp_reference_freq_reg),
    .time_ticks_i (ticks_two),
    .step_o       (step_two)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer decodes.
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [15:0] freq_reg;
  logic [15:0] freq_next;
  logic        start_prev_reg;
  logic        lockout_reg;
  logic        brake_reg;

  wire mode_on    = power_loss_stop_mode_reg != `MODE_COAST;
  wire auto_mode  = (power_loss_stop_mode_reg == `MODE_AUTO_STOP) ||
                    (power_loss_stop_mode_reg == `MODE_AUTO_REACC);
  wire reaccel    = (power_loss_stop_mode_reg == `MODE_REACCEL) ||
                    (power_loss_stop_mode_reg == `MODE_AUTO_REACC);
  wire restart_on = restart_coast_time_reg != `SETTING_OFF;
  wire loss_event = supply_i.undervoltage || supply_i.power_fail ||
                    (supply_i.phase_loss && phase_loss_detect_enable);
  wire decel_ok   = mode_on && !restart_on;
  wire start_lvl  = start_i.forward_start_cmd || start_i.reverse_start_cmd;
  wire start_rise = start_lvl && !start_prev_reg;

  // Initial subtraction, skipped below the threshold (unless it is THRESH_ALWAYS) and in automatic modes.
  wire do_sub = !auto_mode && ((subtract_start_threshold_reg == `THRESH_ALWAYS) ||
                (freq_reg >= subtract_start_threshold_reg));
  wire [15:0] onset_freq = !do_sub ? freq_reg :
                           (freq_reg > decel_start_subtract_freq_reg) ?
                           freq_reg - decel_start_subtract_freq_reg : 16'h0000;
  wire onset_zero = do_sub && (freq_reg <= decel_start_subtract_freq_reg);

  wire [15:0] slope_step_sel = (auto_mode || freq_reg > slope_switchover_freq_reg) ?
                               step_one : step_two;
  // In automatic modes the bus regulator pauses the ramp while the bus is high.
  wire [15:0] dec_step = (auto_mode && bus_excess_i) ? 16'h0000 : slope_step_sel;
  wire [15:0] ramp_down = (freq_reg > dec_step) ? freq_reg - dec_step : 16'h0000;
  // A set frequency below the present one is taken at once; the unsigned gap would wrap.
  wire [15:0] ramp_up   = ((set_freq_reg > freq_reg) && (set_freq_reg - freq_reg > `RST_ACCEL_STEP)) ?
                          freq_reg + `RST_ACCEL_STEP : set_freq_reg;

  always_comb begin
    state_next = state_reg;
    freq_next  = freq_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (loss_event && freq_reg != 16'h0000) begin
          if (!decel_ok) state_next = ST_COAST;
          else begin
            state_next = onset_zero ? ST_STOP : ST_DECEL;
            freq_next  = onset_freq;
          end
        end else if (tick && !lockout_reg && start_lvl) freq_next = ramp_up;
        else if (tick && !start_lvl) freq_next = 16'h0000;
      end
      ST_DECEL: begin
        if (!loss_event && reaccel) state_next = ST_RUN;
        else if (tick) begin
          freq_next = ramp_down;
          if (ramp_down == 16'h0000) state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        freq_next = 16'h0000;
        if (!loss_event && start_rise) state_next = ST_RUN;
      end
      ST_COAST: begin
        freq_next = 16'h0000;
        if (!loss_event) state_next = ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_reg      <= ST_RUN;
      freq_reg       <= 16'h0000;
      start_prev_reg <= 1'b1;
      lockout_reg    <= 1'b1;
      brake_reg      <= 1'b0;
    end else begin
      state_reg      <= state_next;
      freq_reg       <= freq_next;
      start_prev_reg <= start_lvl;
      // After power-up or a stop, a held start is ignored until it drops; a fresh rise releases it.
      if (state_next == ST_STOP || state_next == ST_COAST) lockout_reg <= 1'b1;
      else if (!start_lvl || start_rise) lockout_reg <= 1'b0;
      brake_reg      <= (state_reg == ST_RUN) && (state_next == ST_STOP);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      out_freq_o                <= 16'h0000;
      coast_o                   <= 1'b0;
      dc_brake_o                <= 1'b0;
      power_loss_decel_status_o <= 1'b0;
    end else begin
      out_freq_o                <= freq_next;
      coast_o                   <= state_next == ST_COAST;
      dc_brake_o                <= brake_reg;
      power_loss_decel_status_o <= status_negative ^
                                   (state_next == ST_DECEL || state_next == ST_STOP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states.
  wire [31:0] rd_mux =
    (paddr_i == `ADDR_MODE)       ? {24'h000000, power_loss_stop_mode_reg} :
    (paddr_i == `ADDR_SUBTRACT)   ? {16'h0000, decel_start_subtract_freq_reg} :
    (paddr_i == `ADDR_THRESHOLD)  ? {16'h0000, subtract_start_threshold_reg} :
    (paddr_i == `ADDR_SLOPE_ONE)  ? {16'h0000, power_loss_slope_one_reg} :
    (paddr_i == `ADDR_SLOPE_TWO)  ? {16'h0000, power_loss_slope_two_reg} :
    (paddr_i == `ADDR_SWITCHOVER) ? {16'h0000, slope_switchover_freq_reg} :
    (paddr_i == `ADDR_REF_FREQ)   ? {16'h0000, ramp_reference_freq_reg} :
    (paddr_i == `ADDR_CONFIG)     ? {29'h00000000, config_reg} :
    (paddr_i == `ADDR_COAST_TIME) ? {16'h0000, restart_coast_time_reg} :
    (paddr_i == `ADDR_SET_FREQ)   ? {16'h0000, set_freq_reg} :
    (paddr_i == `ADDR_STATUS)     ? {26'h0000000, lockout_reg, loss_event, state_reg} :
    (paddr_i == `ADDR_OUT_FREQ)   ? {16'h0000, freq_reg} : 32'h00000000;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup && (!known || (pwrite_i && read_only));
      prdata_o  <= (setup && !pwrite_i && known) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      power_loss_stop_mode_reg      <= `RST_MODE;
      decel_start_subtract_freq_reg <= `RST_SUBTRACT;
      subtract_start_threshold_reg  <= `RST_THRESHOLD;
      power_loss_slope_one_reg      <= `RST_SLOPE_ONE;
      power_loss_slope_two_reg      <= `RST_SLOPE_TWO;
      slope_switchover_freq_reg     <= `RST_SWITCHOVER;
      ramp_reference_freq_reg       <= `RST_REF_FREQ;
      config_reg                    <= 3'b000;
      restart_coast_time_reg        <= `RST_COAST_TIME;
      set_freq_reg                  <= `RST_SET_FREQ;
    end else if (wr_en && pready_o) begin
      unique case (paddr_i)
        `ADDR_MODE:       power_loss_stop_mode_reg      <= pwdata_i[7:0];
        `ADDR_SUBTRACT:   decel_start_subtract_freq_reg <= pwdata_i[15:0];
        `ADDR_THRESHOLD:  subtract_start_threshold_reg  <= pwdata_i[15:0];
        `ADDR_SLOPE_ONE:  power_loss_slope_one_reg      <= pwdata_i[15:0];
        `ADDR_SLOPE_TWO:  power_loss_slope_two_reg      <= pwdata_i[15:0];
        `ADDR_SWITCHOVER: slope_switchover_freq_reg     <= pwdata_i[15:0];
        `ADDR_REF_FREQ:   ramp_reference_freq_reg       <= pwdata_i[15:0];
        `ADDR_CONFIG:     config_reg                    <= pwdata_i[2:0];
        `ADDR_COAST_TIME: restart_coast_time_reg        <= pwdata_i[15:0];
        `ADDR_SET_FREQ:   set_freq_reg                  <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end
endmodule : power_loss_decel
`default_nettype wire

// ---- hdl/power_loss_pkg.sv ----
/*
  Types shared by the power-loss sequencer and its helpers.
  Assumes the constants header is included by the user modules.
*/
`default_nettype none
package power_loss_pkg;
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_DECEL = 4'b0010,
    ST_STOP  = 4'b0100,
    ST_COAST = 4'b1000
  } seq_state_t;

  typedef struct packed {
    logic undervoltage;
    logic power_fail;
    logic phase_loss;
    logic supply_ok;
  } supply_t;

  typedef struct packed {
    logic forward_start_cmd;
    logic reverse_start_cmd;
  } start_t;
endpackage : power_loss_pkg
`default_nettype wire

// ---- hdl/slope_step.sv ----
/*
  Converts a slope time setting into a per-tick frequency decrement.
  Assumes the quotient settles well before the next ramp tick after a setting change; the
  divider is iterative, so a fresh value lags a register write by 33 to 66 cycles.
*/
`default_nettype none
module slope_step (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic [15:0] ref_freq_i,
  input  wire logic [15:0] time_ticks_i,
  output var  logic [15:0] step_o
);
  logic [31:0] num_reg;
  logic [31:0] rem_reg;
  logic [31:0] quo_reg;
  logic [5:0]  bit_reg;
  wire  [31:0] trial = {rem_reg[30:0], num_reg[31]};
  wire         fits  = (trial >= {16'h0000, time_ticks_i}) && (time_ticks_i != 16'h0000);

  // Linear ramp: decrement = reference / ticks, restarted continuously.
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      num_reg <= 32'h00000000;
      rem_reg <= 32'h00000000;
      quo_reg <= 32'h00000000;
      bit_reg <= 6'h00;
      step_o  <= 16'h0000;
    end else if (bit_reg == 6'h00) begin
      num_reg <= {ref_freq_i, 16'h0000} >> 16;
      rem_reg <= 32'h00000000;
      quo_reg <= 32'h00000000;
      bit_reg <= 6'h20;
      if (time_ticks_i == 16'h0000) step_o <= ref_freq_i;
      else step_o <= (quo_reg[31:16] != 16'h0000) ? 16'hffff : ((quo_reg[15:0] == 16'h0000) ? 16'h0001 : quo_reg[15:0]);
    end else begin
      num_reg <= {num_reg[30:0], 1'b0};
      rem_reg <= fits ? trial - {16'h0000, time_ticks_i} : trial;
      quo_reg <= {quo_reg[30:0], fits};
      bit_reg <= bit_reg - 6'h01;
    end
  end
endmodule : slope_step
`default_nettype wire

// ---- hdl/tick_divider.sv ----
/*
  One-cycle tick enable at the ramp update rate.
  Assumes a single clock and a synchronous active-low reset.
*/
`include "power_loss_cfg.svh"
`default_nettype none
module tick_divider (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  output var  logic tick_o
);
  localparam int unsigned DIV = `TICK_DIV;
  logic [13:0] cnt_reg;
  wire         wrap = (cnt_reg == 14'(DIV - 1));

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cnt_reg <= 14'h0000;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 14'h0000 : cnt_reg + 14'h0001;
      tick_o  <= wrap;
    end
  end
endmodule : tick_divider
`default_nettype wire

// ---- verification/motor_side_model.sv ----
/*
  Far side of the sequencer: mains sensing, start switch and bus regulator.
  Assumes the bench changes its requests just after a rising edge.
*/
`default_nettype none
module motor_side_model
  import power_loss_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic [2:0]              loss_i,
  input  wire logic                    run_i,
  input  wire logic                    excess_i,
  output var  power_loss_pkg::supply_t supply_o,
  output var  power_loss_pkg::start_t  start_o,
  output var  logic                    bus_excess_o
);
  initial begin
    supply_o     = '0;
    start_o      = '0;
    bus_excess_o = 1'b0;
  end
  // Sensing lags one clock, as a real input filter would.
  always @(posedge mclk_i) begin
    supply_o     <= {loss_i, ~|loss_i};
    start_o      <= {run_i, 1'b0};
    bus_excess_o <= excess_i;
  end
endmodule : motor_side_model
`default_nettype wire

// ---- verification/power_loss_monitor.sv ----
/*
  Port checker for the power-loss sequencer, bound to its top module.
  Assumes one clock and a synchronous active-low reset.
*/
`default_nettype none
module power_loss_monitor
  import power_loss_pkg::*;
(
  input wire logic                    mclk_i,
  input wire logic                    rstn_i,
  input wire logic                    psel_i,
  input wire logic                    penable_i,
  input wire logic [11:0]             paddr_i,
  input wire logic [31:0]             prdata_o,
  input wire logic                    pready_o,
  input wire logic                    pslverr_o,
  input wire power_loss_pkg::supply_t supply_i,
  input wire logic [15:0]             out_freq_o,
  input wire logic                    coast_o,
  input wire logic                    dc_brake_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  // Phase loss is left out of main_lost because it only counts when enabled.
  wire logic main_lost = supply_i.undervoltage | supply_i.power_fail;
  wire logic any_lost  = main_lost | supply_i.phase_loss;
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  sequence answer_s;
    psel_i && penable_i && pready_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  apb_answer_a: assert property (setup_s |=> answer_s)
    else $error("no answer in the access cycle");
  ready_place_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside an access cycle");
  unmapped_err_a: assert property (setup_s ##0 (paddr_i > 12'h02c) |=> pslverr_o)
    else $error("unmapped address without error");
  idle_data_a: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside an access");
  brake_pulse_a: assert property (dc_brake_o |=> !dc_brake_o)
    else $error("brake pulse longer than one cycle");
  brake_cause_a: assert property (dc_brake_o |-> out_freq_o == 16'h0 && $past(any_lost))
    else $error("brake without loss or with frequency");
  coast_cause_a: assert property ($rose(coast_o) |-> $past(any_lost))
    else $error("coast without a supply loss");
  loss_no_rise_a: assert property (main_lost |=> out_freq_o <= $past(out_freq_o))
    else $error("frequency rose during supply loss");
  rise_step_a: assert property (out_freq_o > $past(out_freq_o) |-> out_freq_o == $past(out_freq_o) + 16'h1)
    else $error("frequency rose by more than one step");
  rise_hold_a: assert property (out_freq_o > $past(out_freq_o) |=> $stable(out_freq_o) [*8])
    else $error("frequency rose faster than the tick");
endmodule : power_loss_monitor

bind power_loss_decel power_loss_monitor mon_u (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .supply_i(supply_i), .out_freq_o(out_freq_o), .coast_o(coast_o), .dc_brake_o(dc_brake_o)
);
`default_nettype wire

// ---- verification/test_power_loss_decel.sv ----
/*
  Self-checking bench for the power-loss sequencer.
  Assumes a 10 MHz clock; ramps are kept to a few 0.01 Hz steps to bound the run.
*/
`include "power_loss_cfg.svh"
`default_nettype none
module test_power_loss_decel;
  import power_loss_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i, rstn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        bus_excess, coast_o, dc_brake_o, status_o, run_req, excess_req, er;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [15:0] out_freq_o;
  logic [2:0]  loss_req;
  supply_t     supply;
  start_t      start;
  int          bad_count, n_checks;

  power_loss_decel dut_u (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .supply_i(supply), .start_i(start),
    .bus_excess_i(bus_excess), .out_freq_o(out_freq_o), .coast_o(coast_o),
    .dc_brake_o(dc_brake_o), .power_loss_decel_status_o(status_o));
  motor_side_model far_u (
    .mclk_i(mclk_i), .loss_i(loss_req), .run_i(run_req), .excess_i(excess_req),
    .supply_o(supply), .start_o(start), .bus_excess_o(bus_excess));

  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("Error t=%0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask : chk

  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : chk1

  // The master never assumes a latency; it waits for ready, or at most 20 clocks.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    chk1(pready_o, 1'b1);
    if (k >= 20) summarize();
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk1(er, 1'b0);
  endtask : wr

  task automatic wait_on(input logic s, input logic [15:0] v, input int n);
    int k;
    k = 0;
    while ((s ? {15'h0, status_o} : out_freq_o) !== v && k < n) begin
      @(posedge mclk_i);
      k++;
    end
    chk(s ? {31'h0, status_o} : {16'h0, out_freq_o}, {16'h0, v});
    if (k >= n) summarize();
  endtask : wait_on

  task automatic toggle();
    run_req <= 1'b0;
    repeat (5) @(posedge mclk_i);
    run_req <= 1'b1;
    wait_on(1'b0, 16'h1, 12000);
  endtask : toggle
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, `ADDR_SUBTRACT, 32'h0);
    chk(rd, 32'h12c);
    apb(1'b0, `ADDR_THRESHOLD, 32'h0);
    chk(rd, 32'h1770);
    apb(1'b0, `ADDR_SLOPE_TWO, 32'h0);
    chk(rd, 32'h270f);
    apb(1'b0, `ADDR_COAST_TIME, 32'h0);
    chk(rd, 32'h270f);
    apb(1'b0, 12'h030, 32'h0);
    chk1(er, 1'b1);
    apb(1'b1, `ADDR_OUT_FREQ, 32'h5);
    chk1(er, 1'b1);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_stop();
    wr(`ADDR_CONFIG, 32'h1);
    wr(`ADDR_SLOPE_ONE, 32'h1);
    wr(`ADDR_THRESHOLD, 32'h270f);
    wr(`ADDR_SUBTRACT, 32'h1);
    wr(`ADDR_SET_FREQ, 32'h2);
    wr(`ADDR_MODE, 32'h1);
    run_req <= 1'b1;
    wait_on(1'b0, 16'h2, 30000);
    loss_req <= 3'b100;
    wait_on(1'b1, 16'h1, 20);
    chk(out_freq_o, 32'h1);
    loss_req <= 3'b000;
    wait_on(1'b0, 16'h0, 12000);
    chk1(status_o, 1'b1);
    wr(`ADDR_SET_FREQ, 32'h1);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h4);
    toggle();
    chk1(status_o, 1'b0);
    $display("t_stop done");
  endtask : t_stop

  task automatic t_brake();
    wr(`ADDR_SUBTRACT, 32'h12c);
    loss_req <= 3'b010;
    wait_on(1'b1, 16'h1, 20);
    // The brake pulse trails the status by one clock.
    @(posedge mclk_i);
    chk1(dc_brake_o, 1'b1);
    chk(out_freq_o, 32'h0);
    loss_req <= 3'b000;
    toggle();
    $display("t_brake done");
  endtask : t_brake

  task automatic t_reaccel();
    loss_req <= 3'b001;
    repeat (20) @(posedge mclk_i);
    chk1(status_o, 1'b0);
    loss_req <= 3'b000;
    wr(`ADDR_MODE, 32'h16);
    wr(`ADDR_CONFIG, 32'h3);
    excess_req <= 1'b1;
    loss_req   <= 3'b001;
    wait_on(1'b1, 16'h1, 20);
    chk(out_freq_o, 32'h1);
    loss_req <= 3'b000;
    wait_on(1'b1, 16'h0, 20);
    chk(out_freq_o, 32'h1);
    $display("t_reaccel done");
  endtask : t_reaccel

  task automatic t_auto_stop();
    wr(`ADDR_MODE, 32'h15);
    loss_req <= 3'b100;
    wait_on(1'b1, 16'h1, 20);
    loss_req <= 3'b000;
    repeat (50) @(posedge mclk_i);
    chk1(status_o, 1'b1);
    excess_req <= 1'b0;
    wait_on(1'b0, 16'h0, 12000);
    toggle();
    $display("t_auto_stop done");
  endtask : t_auto_stop

  task automatic t_coast();
    wr(`ADDR_COAST_TIME, 32'h32);
    loss_req <= 3'b100;
    repeat (4) @(posedge mclk_i);
    chk1(coast_o, 1'b1);
    chk1(status_o, 1'b0);
    loss_req <= 3'b000;
    wr(`ADDR_COAST_TIME, 32'h270f);
    toggle();
    wr(`ADDR_MODE, 32'h0);
    loss_req <= 3'b100;
    repeat (4) @(posedge mclk_i);
    chk1(coast_o, 1'b1);
    chk1(status_o, 1'b0);
    wr(`ADDR_CONFIG, 32'h5);
    repeat (2) @(posedge mclk_i);
    chk1(status_o, 1'b1);
    loss_req <= 3'b000;
    $display("t_coast done");
  endtask : t_coast
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count  = 0;
    n_checks   = 0;
    rstn_i     = 1'b0;
    psel_i     = 1'b0;
    penable_i  = 1'b0;
    pwrite_i   = 1'b0;
    paddr_i    = 12'h0;
    pwdata_i   = 32'h0;
    loss_req   = 3'b000;
    run_req    = 1'b0;
    excess_req = 1'b0;
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_stop();
    t_brake();
    t_reaccel();
    t_auto_stop();
    t_coast();
    summarize();
  end
endmodule : test_power_loss_decel
`default_nettype wire
